// file: shared/clkdiv_defs.svh
// named constants for the half-rate / slow-rate clock divider
`ifndef CLKDIV_DEFS_SVH
`define CLKDIV_DEFS_SVH

`define DIV_SLOW_LO    4
`define DIV_SLOW_HI    6
`define PH_W           3
`define PH_START       3'h7
`define PH_FIRST       3'h0
`define PH_STEP        3'h1
`define SYNC_W         4
`define SYNC_CLK       0
`define SYNC_HOLD      1
`define SYNC_RATIO     2
`define SYNC_CLEAR     3

`endif

// file: shared/clkdiv_pkg.sv
// types shared by the divider design files
package clkdiv_pkg;

  `include "clkdiv_defs.svh"

  typedef struct packed {
    logic [`PH_W-1:0] ph;
    logic             clk_prev;
    logic             hold;
    logic             half;
    logic             half_inv;
    logic             slow;
    logic             slow_inv;
    logic             align;
    logic             align_inv;
  } div_state_t;

endpackage

// file: rtl/pin_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // ==========================================================
  // state
  logic [1:0][WIDTH-1:0] stage;
  logic [1:0][WIDTH-1:0] next_stage;

  always_comb begin
    next_stage[0] = d;
    next_stage[1] = stage[0];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stage <= '0;
    end else begin
      stage <= next_stage;
    end
  end

  assign q = stage[1];

endmodule

// file: rtl/clock_divider_2_4_6_phase_sync.sv
// half-rate and 4/6 slow-rate divider with hold, clear and alignment pulse
`timescale 1ns/1ps

// Overview of operation
// R01: the half-rate pairs toggle on every divided input rising edge.
// R02: the slow-rate pairs divide by 4 with ratio_choice low, by 6 high.
// R03: one phase counter drives every stage so common edges coincide.
// R04: hold is captured on the falling input edge, so no runt pulse arises.
// R05: clear low and hold low divides; hold high freezes the half and slow outputs, and the align pair drops at the next rise.
// R06: while divider_clear is high all divider outputs are held reset.
// R07: the alignment pulse is high for one input period at common rises.
// R08: the system clears several devices after power-up to run in step.
// R09: an out-of-range phase wraps to the common start, keeping sync.
// R10: two identical true/complement pairs per rate plus an align pair.
// R11: after clear release the true outputs start low and rise together first.
module clock_divider_2_4_6_phase_sync
  import clkdiv_pkg::*;
#(
  parameter int DIV_LO = `DIV_SLOW_LO,
  parameter int DIV_HI = `DIV_SLOW_HI
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       clk_in,
  input  wire logic       hold_req,
  input  wire logic       ratio_choice,
  input  wire logic       divider_clear,
  output logic      [1:0] half_rate_outputs,
  output logic      [1:0] half_rate_outputs_inv,
  output logic      [1:0] slow_rate_outputs,
  output logic      [1:0] slow_rate_outputs_inv,
  output logic            align_pulse,
  output logic            align_pulse_inv
);

  localparam logic [`PH_W-1:0] RATIO_LO = (`PH_W)'(DIV_LO);
  localparam logic [`PH_W-1:0] RATIO_HI = (`PH_W)'(DIV_HI);

  // ==========================================================
  // pin synchronisers
  logic [`SYNC_W-1:0] pins;
  logic [`SYNC_W-1:0] pins_s;

  assign pins[`SYNC_CLK]   = clk_in;
  assign pins[`SYNC_HOLD]  = hold_req;
  assign pins[`SYNC_RATIO] = ratio_choice;
  assign pins[`SYNC_CLEAR] = divider_clear;

  pin_sync #(
    .WIDTH (`SYNC_W)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       (pins),
    .q       (pins_s)
  );

  logic s_clk;
  logic s_hold;
  logic s_ratio;
  logic s_clear;

  assign s_clk   = pins_s[`SYNC_CLK];
  assign s_hold  = pins_s[`SYNC_HOLD];
  assign s_ratio = pins_s[`SYNC_RATIO];
  assign s_clear = pins_s[`SYNC_CLEAR];

  // ==========================================================
  // divider state
  localparam div_state_t ST_RESET = '{
    ph:        `PH_START,
    clk_prev:  1'b0,
    hold:      1'b0,
    half:      1'b0,
    half_inv:  1'b1,
    slow:      1'b0,
    slow_inv:  1'b1,
    align:     1'b0,
    align_inv: 1'b1
  };

  div_state_t       st;
  div_state_t       next_st;
  logic             rise;
  logic             fall;
  logic             adv;
  logic [`PH_W-1:0] ratio;
  logic [`PH_W-1:0] ph_n;
  logic             common_rise;

  assign rise  = s_clk & ~st.clk_prev;
  assign fall  = ~s_clk & st.clk_prev;
  assign adv   = rise & ~st.hold & ~s_clear;
  assign ratio = s_ratio ? RATIO_HI : RATIO_LO; // R02
  assign ph_n  = (st.ph >= ratio - `PH_STEP) ? `PH_FIRST
                                              : st.ph + `PH_STEP; // R09
  // both rates go from low to high at this rise
  assign common_rise = ~ph_n[0] && !st.half
                       && (ph_n < (ratio >> 1)) && !st.slow; // R07

  always_comb begin
    next_st          = st;
    next_st.clk_prev = s_clk;
    if (fall) begin
      next_st.hold = s_hold; // R04
    end
    if (s_clear) begin
      next_st.ph        = `PH_START; // R06
      next_st.half      = 1'b0;
      next_st.half_inv  = 1'b1;
      next_st.slow      = 1'b0;
      next_st.slow_inv  = 1'b1;
      next_st.align     = 1'b0;
      next_st.align_inv = 1'b1;
    end else if (rise && !st.hold) begin
      next_st.ph        = ph_n; // R03
      next_st.half      = ~ph_n[0]; // R01
      next_st.half_inv  = ph_n[0];
      next_st.slow      = ph_n < (ratio >> 1); // R02
      next_st.slow_inv  = ph_n >= (ratio >> 1);
      next_st.align     = common_rise; // R07
      next_st.align_inv = ~common_rise;
    end else if (rise) begin
      next_st.align     = 1'b0; // R05
      next_st.align_inv = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= ST_RESET; // R11
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // output pairs
  assign half_rate_outputs     = {2{st.half}}; // R10
  assign half_rate_outputs_inv = {2{st.half_inv}};
  assign slow_rate_outputs     = {2{st.slow}};
  assign slow_rate_outputs_inv = {2{st.slow_inv}};
  assign align_pulse           = st.align;
  assign align_pulse_inv       = st.align_inv;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_common_rise;
    $rose(st.half) && $rose(st.slow);
  endsequence

  chk_half_toggle: assert property ( // R01
    adv && st.ph < ratio |=> st.half != $past(st.half))
    else $error("half-rate output did not toggle");

  chk_slow_phase: assert property ( // R02
    $rose(st.slow) |-> st.ph == `PH_FIRST && st.half)
    else $error("slow-rate rise off the common phase");

  chk_common_edges: assert property ( // R03
    $rose(st.slow) |-> $rose(st.half))
    else $error("slow rise without half rise");

  chk_hold_capture: assert property ( // R04
    fall |=> st.hold == $past(s_hold))
    else $error("hold not captured on falling edge");

  chk_hold_freeze: assert property ( // R05
    rise && st.hold && !s_clear |=> $stable(st.half) && $stable(st.slow))
    else $error("outputs moved while held");

  chk_clear_reset: assert property ( // R06
    s_clear |=> !st.half && !st.slow && !st.align)
    else $error("outputs not reset during clear");

  sequence s_align_stand;
    st.align && !rise && !s_clear;
  endsequence

  sequence s_align_end;
    st.align && rise;
  endsequence

  chk_align_one: assert property ( // R07
    s_align_stand |=> st.align)
    else $error("alignment pulse ended early");

  chk_align_drop: assert property ( // R07
    s_align_end |=> !st.align)
    else $error("alignment pulse longer than one period");

  chk_align_cause: assert property ( // R07
    $rose(st.align) |-> s_common_rise)
    else $error("alignment pulse without common rise");

  chk_wrap_sync: assert property ( // R09
    adv && st.ph >= ratio - `PH_STEP |=> st.ph == `PH_FIRST)
    else $error("phase did not wrap to start");

  chk_pair_compl: assert property ( // R10
    st.half_inv == !st.half && st.slow_inv == !st.slow
      && st.align_inv == !st.align)
    else $error("complement output mismatch");

  chk_clear_release: assert property ( // R11
    $fell(s_clear) |-> st.ph == `PH_START && !st.half && !st.slow)
    else $error("outputs not low at clear release");

endmodule

// file: tb/clk_source.sv
// clock source model driving the divider input pin
`timescale 1ns/1ps

module clk_source #(
  parameter int HALF = 4
) (
  input  wire logic clk_sys,
  input  wire logic run,
  output logic      clk_in
);
  int   cnt = 0;
  logic level = 1'b0;

  assign clk_in = level;

  // stands still low while stopped
  always @(posedge clk_sys) begin
    if (!run) begin
      cnt <= 0;
      level <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      level <= ~level;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// file: tb/testbench.sv
// self-checking bench for the clock divider
`timescale 1ns/1ps

module testbench;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic       run = 1'b0;
  logic       clk_in;
  logic       hold_req = 1'b0;
  logic       ratio_choice = 1'b0;
  logic       divider_clear = 1'b0;
  logic [1:0] h, hi, s, si;
  logic       a, ai;
  logic [9:0] seen;
  int         n_fail = 0;
  int         comparisons = 0;
  int         cycles = 0;

  assign seen = {h, hi, s, si, a, ai};
  always #10 clk_sys = ~clk_sys;

  clk_source src (.clk_sys(clk_sys), .run(run), .clk_in(clk_in));

  clock_divider_2_4_6_phase_sync dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_in(clk_in),
    .hold_req(hold_req), .ratio_choice(ratio_choice),
    .divider_clear(divider_clear), .half_rate_outputs(h),
    .half_rate_outputs_inv(hi), .slow_rate_outputs(s),
    .slow_rate_outputs_inv(si), .align_pulse(a), .align_pulse_inv(ai)
  );

  task automatic summarize();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic compare(input string nm, input logic [9:0] e,
                         input logic [9:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [9:0] pack(input logic x, y, z);
    return {{2{x}}, {2{~x}}, {2{y}}, {2{~y}}, z, ~z};
  endfunction

  // one input rise, then judge; nh is the hold level for the next fall
  task automatic step(input logic x, y, z, nh);
    @(posedge clk_in);
    @(posedge clk_sys);
    hold_req <= nh;
    repeat (5) @(posedge clk_sys);
    compare("outputs", pack(x, y, z), seen);
  endtask

  // clear (clock stopped on the first call, running on later ones), then restart from stopped
  task automatic clear_dev();
    divider_clear <= 1'b1;
    repeat (16) @(posedge clk_sys);
    compare("cleared", pack(0, 0, 0), seen);
    run <= 1'b0;
    divider_clear <= 1'b0;
    repeat (8) @(posedge clk_sys);
    run <= 1'b1;
  endtask

  task automatic run_ratio(input logic r, input int n);
    int m;
    int p;
    m = r ? 6 : 4;
    ratio_choice <= r;
    clear_dev();
    for (int k = 0; k < n; k++) begin
      p = k % m;
      step(p % 2 == 0, p < m / 2, p == 0, 1'b0);
    end
  endtask

  task automatic hold_test();
    ratio_choice <= 1'b0;
    clear_dev();
    step(1, 1, 1, 1);
    step(1, 1, 0, 0);
    step(0, 1, 0, 0);
    step(1, 0, 0, 0);
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    @(posedge clk_sys);
    compare("reset", pack(0, 0, 0), seen);
    run_ratio(1'b0, 8);
    run_ratio(1'b1, 12);
    hold_test();
    summarize();
  end
endmodule
